/* File: pkg/alarm_cond_params.svh */
// Reset values, legal limits and timing figures for the alarm conditioning block.
`ifndef ALARM_COND_PARAMS_SVH
`define ALARM_COND_PARAMS_SVH

// ********************************
// Reset values, legal limits and password value
// ********************************
`define VALVE_OPEN_RST   14'd9999
`define VALVE_OPEN_MAX   14'd9999
`define POT_RANGE_RST    3'd0
`define POT_RANGE_MAX    3'd5
`define FINISH_WIDTH_RST 7'd0
`define FINISH_WIDTH_MAX 7'd100
`define HB_ENABLE_RST    1'b1
`define PASSWORD_VALUE   14'h3f57

// ********************************
// Timing
// ********************************
`define CLK_PERIOD_NS    5
`define FINISH_STEP_MS   100
`define ADV_WAIT_MS      2000

`endif

/* File: pkg/alarm_cond_pkg.sv */
// Types shared by the alarm conditioning block and its bench.
package alarm_cond_pkg;

  typedef enum logic [2:0] {
    LVL_OPERATION   = 3'b000,
    LVL_INITIAL     = 3'b001,
    LVL_COMMS       = 3'b010,
    LVL_ADVANCED    = 3'b011,
    LVL_CALIBRATION = 3'b100,
    LVL_PROTECT     = 3'b101
  } level_t;

  typedef enum logic [3:0] {
    SEL_OPEN_ALARM  = 4'h0,
    SEL_HB_ENABLE   = 4'h1,
    SEL_HB_HOLD     = 4'h2,
    SEL_REARM       = 4'h3,
    SEL_FINISH      = 4'h4,
    SEL_FINISH_CONT = 4'h5,
    SEL_VALVE_OPEN  = 4'h6,
    SEL_POT_RANGE   = 4'h7,
    SEL_ROOT        = 4'h8,
    SEL_UNIT        = 4'h9,
    SEL_RESTORE     = 4'ha,
    SEL_PASSWORD    = 4'hb
  } sel_t;

  typedef struct packed {
    logic [3:0]  open_in_alarm;
    logic        hb_enable;
    logic        heater_burnout_hold;
    logic        standby_rearm_select;
    logic [6:0]  run_finish_pulse_width;
    logic        finish_continuous;
    logic [13:0] valve_open_pos;
    logic [2:0]  pot_range_code;
    logic        root_extract_enable;
    logic        standby_unit_days;
  } cfg_t;

  typedef struct packed {
    cfg_t        cfg;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  prev;
    logic        hb_latched;
    logic        hb_out;
    logic [3:0]  standby;
    logic [3:0]  alarm_out;
    logic [3:0]  aux_out;
    logic [3:0]  aux_ind;
    logic        finish_on;
    logic [6:0]  finish_left;
    logic [28:0] tick;
    logic        restore_busy;
    logic        pw_ok;
    logic [28:0] adv_cnt;
    logic        adv_go;
    logic        locked_prev;
  } state_t;

endpackage : alarm_cond_pkg

/* File: design/alarm_cond.sv */
// Auxiliary output polarity, heater burnout hold, alarm standby re-arm and settings store.
//
// Overview of operation
// - Aux output equals function state, inverted when open-in-alarm; close is default.
// - Aux indicator follows the function state regardless of polarity.
// - Burnout alarm enable defaults on; hold acts only while enabled.
// - Held burnout clears on zero threshold, reset, function key or event cancel.
// - Burnout output forced off in initial, comms, advanced, calibration levels.
// - Program end pulse 0.1 to 10.0 s; zero width gives no pulse.
// - Continuous end output holds until run command arrives in reset status.
// - Re-arm selector: A default, B re-arms only at power-on.
// - Condition A re-arms on any listed operating change event.
// - Re-arm applies only to alarm types 5, 6, 7, 10, 11.
// - Standby alarm outputs forced off in the four setting levels.
// - Restore command returns all settings to defaults and reads back off.
// - Password -169 with protect zero grants advanced level on key or 2 s.
// - Valve open position 0 to 9999, default 9999, written by calibration.
// - Pot range code 0 to 5, default 0, written by calibration.
// - Root extraction enable defaults off; only with analog input support.
// - Standby unit hours-minutes default or days-hours, set before standby time.
`timescale 1ns/100ps
`include "alarm_cond_params.svh"

module alarm_cond #(
  parameter int          ANALOG_INPUT = 1,
  parameter int unsigned STEP_CYCLES  = `FINISH_STEP_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned ADV_CYCLES   = `ADV_WAIT_MS * 1000000 / `CLK_PERIOD_NS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            aux_func,
  output logic [3:0]                 aux_out,
  output logic [3:0]                 aux_indicator,
  input  wire logic                  heater_break_alarm,
  input  wire logic                  hb_threshold_zero,
  input  wire logic                  function_key,
  input  wire logic                  alarm_hold_cancel,
  input  wire logic                  adv_key,
  output logic                       hb_out,
  input  wire logic [3:0]            alarm_raw,
  input  wire logic [3:0][3:0]       alarm_type,
  input  wire logic [8:0]            rearm_event,
  output logic [3:0]                 alarm_out,
  input  wire logic                  program_end,
  input  wire logic                  run_cmd,
  input  wire logic                  in_reset_status,
  output logic                       run_finish_out,
  input  wire alarm_cond_pkg::level_t level,
  input  wire logic                  protect_zero,
  output logic                       advanced_grant,
  input  wire logic                  set_wr,
  input  wire alarm_cond_pkg::sel_t  set_sel,
  input  wire logic [13:0]           set_data,
  input  wire logic                  cal_done,
  input  wire logic [13:0]           cal_open_pos,
  input  wire logic [2:0]            cal_pot_code,
  output alarm_cond_pkg::cfg_t       cfg,
  output logic                       factory_default_restore
);

  // ********************************
  // State
  // ********************************
  alarm_cond_pkg::state_t st;
  alarm_cond_pkg::state_t next_st;
  alarm_cond_pkg::cfg_t   cfg_default;

  localparam logic [28:0] STEP_LAST = 29'(STEP_CYCLES - 1);
  localparam logic [28:0] ADV_LAST  = 29'(ADV_CYCLES - 1);

  logic [2:0] press;
  logic       locked;
  logic       enter_locked;
  logic       cancel;
  logic       rearm;
  logic [3:0] standby_type;

  always_comb begin
    cfg_default                        = '0;
    cfg_default.hb_enable              = `HB_ENABLE_RST;
    cfg_default.run_finish_pulse_width = `FINISH_WIDTH_RST;
    cfg_default.valve_open_pos         = `VALVE_OPEN_RST;
    cfg_default.pot_range_code         = `POT_RANGE_RST;
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    next_st = st;
    next_st.sync1 = {adv_key, alarm_hold_cancel, function_key};
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    press = st.sync2 & ~st.prev;
    cancel = press[0] | press[1];

    locked = (level == alarm_cond_pkg::LVL_INITIAL) || (level == alarm_cond_pkg::LVL_COMMS) ||
             (level == alarm_cond_pkg::LVL_ADVANCED) ||
             (level == alarm_cond_pkg::LVL_CALIBRATION);
    enter_locked = locked & ~st.locked_prev;
    next_st.locked_prev = locked;

    // Polarity is applied after the function state so the indicator never inverts.
    next_st.aux_out = aux_func ^ st.cfg.open_in_alarm;
    next_st.aux_ind = aux_func;

    // Heater burnout. A new detection wins over a cancel in the same cycle;
    // level entry and a zero threshold always clear.
    if (!st.cfg.hb_enable || !st.cfg.heater_burnout_hold) begin
      next_st.hb_latched = 1'b0;
    end else if (enter_locked || hb_threshold_zero) begin
      next_st.hb_latched = 1'b0;
    end else if (heater_break_alarm) begin
      next_st.hb_latched = 1'b1;
    end else if (cancel) begin
      next_st.hb_latched = 1'b0;
    end
    next_st.hb_out = st.cfg.hb_enable && !locked && !hb_threshold_zero &&
                     (heater_break_alarm || (st.cfg.heater_burnout_hold && st.hb_latched));

    // Standby sequence: an alarm stays suppressed after re-arm until its
    // condition has been seen clear once.
    rearm = !st.cfg.standby_rearm_select && (rearm_event != 9'h000);
    for (int i = 0; i < 4; i++) begin
      standby_type[i] = (alarm_type[i] == 4'h5) || (alarm_type[i] == 4'h6) ||
                        (alarm_type[i] == 4'h7) || (alarm_type[i] == 4'ha) ||
                        (alarm_type[i] == 4'hb);
      if (!standby_type[i]) begin
        next_st.standby[i] = 1'b0;
      end else if (rearm) begin
        next_st.standby[i] = 1'b1;
      end else if (!alarm_raw[i]) begin
        next_st.standby[i] = 1'b0;
      end
      next_st.alarm_out[i] = alarm_raw[i] &&
                             !(standby_type[i] && (st.standby[i] || locked));
    end

    // Program end output.
    if (st.cfg.finish_continuous && st.finish_on) begin
      if (run_cmd && in_reset_status) begin
        next_st.finish_on = 1'b0;
      end
    end else if (st.finish_on) begin
      if (st.tick == STEP_LAST) begin
        next_st.tick = '0;
        if (st.finish_left == 7'd1) begin
          next_st.finish_on = 1'b0;
        end
        next_st.finish_left = st.finish_left - 7'd1;
      end else begin
        next_st.tick = st.tick + 29'd1;
      end
    end
    if (program_end && !st.finish_on) begin
      if (st.cfg.finish_continuous) begin
        next_st.finish_on = 1'b1;
      end else if (st.cfg.run_finish_pulse_width != 7'd0) begin
        next_st.finish_on   = 1'b1;
        next_st.finish_left = st.cfg.run_finish_pulse_width;
        next_st.tick        = '0;
      end
    end

    // Password and advanced level entry.
    next_st.adv_go = 1'b0;
    if (st.pw_ok) begin
      if (press[2] || st.adv_cnt == ADV_LAST) begin
        next_st.pw_ok  = 1'b0;
        next_st.adv_go = 1'b1;
      end else begin
        next_st.adv_cnt = st.adv_cnt + 29'd1;
      end
    end

    // Settings store. Out-of-range values are ignored so the stored set stays legal.
    next_st.restore_busy = 1'b0;
    if (cal_done) begin
      next_st.cfg.valve_open_pos = cal_open_pos <= `VALVE_OPEN_MAX ? cal_open_pos
                                   : st.cfg.valve_open_pos;
      next_st.cfg.pot_range_code = cal_pot_code <= `POT_RANGE_MAX ? cal_pot_code
                                   : st.cfg.pot_range_code;
    end
    if (set_wr) begin
      unique case (set_sel)
        alarm_cond_pkg::SEL_OPEN_ALARM:  next_st.cfg.open_in_alarm = set_data[3:0];
        alarm_cond_pkg::SEL_HB_ENABLE:   next_st.cfg.hb_enable = set_data[0];
        alarm_cond_pkg::SEL_HB_HOLD:     next_st.cfg.heater_burnout_hold = set_data[0];
        alarm_cond_pkg::SEL_REARM:       next_st.cfg.standby_rearm_select = set_data[0];
        alarm_cond_pkg::SEL_FINISH: begin
          if (set_data[6:0] <= `FINISH_WIDTH_MAX && set_data[13:7] == 7'h00) begin
            next_st.cfg.run_finish_pulse_width = set_data[6:0];
          end
        end
        alarm_cond_pkg::SEL_FINISH_CONT: next_st.cfg.finish_continuous = set_data[0];
        alarm_cond_pkg::SEL_VALVE_OPEN: begin
          if (set_data <= `VALVE_OPEN_MAX) begin
            next_st.cfg.valve_open_pos = set_data;
          end
        end
        alarm_cond_pkg::SEL_POT_RANGE: begin
          if (set_data[2:0] <= `POT_RANGE_MAX && set_data[13:3] == 11'h000) begin
            next_st.cfg.pot_range_code = set_data[2:0];
          end
        end
        alarm_cond_pkg::SEL_ROOT:
          next_st.cfg.root_extract_enable = set_data[0] && (ANALOG_INPUT != 0);
        alarm_cond_pkg::SEL_UNIT:        next_st.cfg.standby_unit_days = set_data[0];
        alarm_cond_pkg::SEL_RESTORE: begin
          if (set_data[0]) begin
            next_st.cfg          = cfg_default;
            next_st.restore_busy = 1'b1;
          end
        end
        alarm_cond_pkg::SEL_PASSWORD: begin
          if (protect_zero && level == alarm_cond_pkg::LVL_INITIAL &&
              set_data == `PASSWORD_VALUE) begin
            next_st.pw_ok   = 1'b1;
            next_st.adv_cnt = '0;
          end
        end
        default: ;
      endcase
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st               <= '0;
      st.cfg           <= cfg_default;
      st.standby       <= 4'hf;
      st.locked_prev   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign aux_out                 = st.aux_out;
  assign aux_indicator           = st.aux_ind;
  assign hb_out                  = st.hb_out;
  assign alarm_out               = st.alarm_out;
  assign run_finish_out          = st.finish_on;
  assign advanced_grant          = st.adv_go;
  assign cfg                     = st.cfg;
  assign factory_default_restore = st.restore_busy;

  // ********************************
  // Checks
  // ********************************
  property p_aux_polarity;
    @(posedge clk) disable iff (rst)
      ##1 aux_out == ($past(aux_func) ^ $past(st.cfg.open_in_alarm));
  endproperty
  a_aux_polarity: assert property (p_aux_polarity) else $error("aux polarity wrong");

  property p_indicator;
    @(posedge clk) disable iff (rst)
      ##1 aux_indicator == $past(aux_func);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator wrong");

  property p_hb_disabled;
    @(posedge clk) disable iff (rst)
      !st.cfg.hb_enable |=> !hb_out;
  endproperty
  a_hb_disabled: assert property (p_hb_disabled) else $error("burnout while disabled");

  property p_hb_hold;
    @(posedge clk) disable iff (rst)
      (st.hb_latched && st.cfg.hb_enable && st.cfg.heater_burnout_hold && !cancel &&
       !hb_threshold_zero && !locked) |=> st.hb_latched;
  endproperty
  a_hb_hold: assert property (p_hb_hold) else $error("burnout hold lost");

  property p_locked_off;
    @(posedge clk) disable iff (rst)
      locked [*2] |-> !hb_out && ((alarm_out & standby_type) == 4'h0);
  endproperty
  a_locked_off: assert property (p_locked_off) else $error("output on in setting level");

  property p_no_pulse;
    @(posedge clk) disable iff (rst)
      (program_end && !st.finish_on && !st.cfg.finish_continuous &&
       st.cfg.run_finish_pulse_width == 7'd0) |=> !run_finish_out;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse at zero width");

  property p_continuous;
    @(posedge clk) disable iff (rst)
      (st.finish_on && st.cfg.finish_continuous && !(run_cmd && in_reset_status))
        |=> run_finish_out;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous output dropped");

  property p_restore;
    @(posedge clk) disable iff (rst)
      factory_default_restore |-> cfg == cfg_default ##1 !factory_default_restore;
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");

  property p_ranges;
    @(posedge clk) disable iff (rst)
      cfg.pot_range_code <= `POT_RANGE_MAX && cfg.valve_open_pos <= `VALVE_OPEN_MAX;
  endproperty
  a_ranges: assert property (p_ranges) else $error("stored value out of range");

  property p_grant;
    @(posedge clk) disable iff (rst)
      advanced_grant |-> $past(st.pw_ok) && !st.pw_ok;
  endproperty
  a_grant: assert property (p_grant) else $error("grant without password");

  property p_finish_start;
    @(posedge clk) disable iff (rst)
      (program_end && !st.finish_on && !st.cfg.finish_continuous &&
       st.cfg.run_finish_pulse_width != 7'd0) |=> run_finish_out;
  endproperty
  a_finish_start: assert property (p_finish_start) else $error("end pulse missing");

  property p_cancel_clears;
    @(posedge clk) disable iff (rst)
      (st.hb_latched && cancel && !heater_break_alarm) |=> !st.hb_latched;
  endproperty
  a_cancel_clears: assert property (p_cancel_clears) else $error("cancel ignored");

  property p_rearm_a;
    @(posedge clk) disable iff (rst)
      (!st.cfg.standby_rearm_select && rearm_event != 9'h000)
        |=> st.standby == $past(standby_type);
  endproperty
  a_rearm_a: assert property (p_rearm_a) else $error("re-arm wrong");

  property p_rearm_b;
    @(posedge clk) disable iff (rst)
      (st.cfg.standby_rearm_select && st.standby == 4'h0) |=> st.standby == 4'h0;
  endproperty
  a_rearm_b: assert property (p_rearm_b) else $error("re-arm under condition B");

  c_hb_latch:  cover property (@(posedge clk) disable iff (rst) st.hb_latched ##1 cancel);
  c_finish:    cover property (@(posedge clk) disable iff (rst) $fell(run_finish_out));
  c_standby:   cover property (@(posedge clk) disable iff (rst) $fell(st.standby[0]));
  c_grant:     cover property (@(posedge clk) disable iff (rst) advanced_grant);
  c_restore:   cover property (@(posedge clk) disable iff (rst) factory_default_restore);

endmodule : alarm_cond

/* File: verif/alarm_partner.sv */
// Operator side model: front function key, a hold-cancel event input and the level key.
`timescale 1ns/100ps

module alarm_partner (
  input  wire logic clk,
  output logic      function_key,
  output logic      alarm_hold_cancel,
  output logic      adv_key
);
  // ********************************
  // Key presses
  // ********************************
  initial begin
    function_key      = 1'h0;
    alarm_hold_cancel = 1'h0;
    adv_key           = 1'h0;
  end

  // Presses land off the clock grid, as a hand would, so the synchroniser is really used.
  task automatic press(input int k, input int held);
    #1.7;
    case (k)
      0: function_key = 1'h1;
      1: alarm_hold_cancel = 1'h1;
      default: adv_key = 1'h1;
    endcase
    repeat (held) @(posedge clk);
    #1.7;
    {function_key, alarm_hold_cancel, adv_key} = 3'h0;
  endtask : press
endmodule : alarm_partner

/* File: verif/tb_top.sv */
// Self-checking bench for the alarm conditioning block.
`timescale 1ns/100ps
`include "alarm_cond_params.svh"

module tb_top;
  // ********************************
  // Stimulus and scoreboard
  // ********************************
  localparam int STEP = 10;
  localparam int ADV  = 20;
  localparam int LIM  = 10000;
  logic                          clk = 1'h0;
  logic                          rst = 1'h1;
  logic [3:0]                    aux_func = 4'h0;
  logic                          heater_break_alarm = 1'h0;
  logic                          hb_threshold_zero = 1'h0;
  logic [3:0]                    alarm_raw = 4'h0;
  logic [3:0][3:0]               alarm_type = 16'h0;
  logic [8:0]                    rearm_event = 9'h0;
  logic                          program_end = 1'h0;
  logic                          run_cmd = 1'h0;
  logic                          in_reset_status = 1'h0;
  alarm_cond_pkg::level_t        level = alarm_cond_pkg::LVL_OPERATION;
  logic                          protect_zero = 1'h0;
  logic                          set_wr = 1'h0;
  alarm_cond_pkg::sel_t          set_sel = alarm_cond_pkg::SEL_OPEN_ALARM;
  logic [13:0]                   set_data = 14'h0;
  logic                          cal_done = 1'h0;
  logic [13:0]                   cal_open_pos = 14'h0;
  logic [2:0]                    cal_pot_code = 3'h0;
  logic [3:0]                    aux_out, aux_indicator, alarm_out, oia;
  logic                          hb_out, run_finish_out, advanced_grant, factory_default_restore;
  logic                          function_key, alarm_hold_cancel, adv_key;
  alarm_cond_pkg::cfg_t          cfg;
  logic [63:0]                   seen_v, exp_q[$];
  int                            sel_q[$];
  int                            n_mismatch = 0;
  int                            tests_run = 0;
  int                            seed = 8051;
  int                            cyc = 0;
  int                            hi_n, fdr_n;
  logic [13:0]                   pw_tab[4] = '{14'h0, 14'h1, 14'h7, 14'h64};
  event                          look;

  always #2.5 clk = ~clk;

  alarm_cond #(.STEP_CYCLES(STEP), .ADV_CYCLES(ADV)) i_alarm_cond (.clk, .rst, .aux_func,
    .aux_out, .aux_indicator, .heater_break_alarm, .hb_threshold_zero, .function_key,
    .alarm_hold_cancel, .adv_key, .hb_out, .alarm_raw, .alarm_type, .rearm_event, .alarm_out,
    .program_end, .run_cmd, .in_reset_status, .run_finish_out, .level, .protect_zero,
    .advanced_grant, .set_wr, .set_sel, .set_data, .cal_done, .cal_open_pos, .cal_pot_code,
    .cfg, .factory_default_restore);

  alarm_partner i_alarm_partner (.clk, .function_key, .alarm_hold_cancel, .adv_key);

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  function automatic logic [63:0] obs(input int s);
    case (s)
      0: return 64'(aux_out);
      1: return 64'(aux_indicator);
      2: return 64'(hb_out);
      3: return 64'(alarm_out);
      4: return 64'(run_finish_out);
      7: return 64'(cfg);
      default: return seen_v;
    endcase
  endfunction : obs

  task automatic note(input int s, input logic [63:0] want);
    sel_q.push_back(s);
    exp_q.push_back(want);
    -> look;
  endtask : note

  always @(look) begin
    while (exp_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
  end

  function automatic alarm_cond_pkg::cfg_t dflt();
    alarm_cond_pkg::cfg_t c;
    c = '0;
    c.hb_enable = `HB_ENABLE_RST;
    c.valve_open_pos = `VALVE_OPEN_RST;
    c.pot_range_code = `POT_RANGE_RST;
    c.run_finish_pulse_width = `FINISH_WIDTH_RST;
    return c;
  endfunction : dflt

  // The strobe is dropped for a cycle so back-to-back writes never touch it twice in one step.
  task automatic wr(input alarm_cond_pkg::sel_t s, input logic [13:0] d);
    set_wr = 1'h1;
    set_sel = s;
    set_data = d;
    step(1);
    set_wr = 1'h0;
    step(1);
  endtask : wr

  task automatic pulse(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
  endtask : pulse

  task automatic wait_grant(input int lim);
    seen_v = 64'h0;
    while (advanced_grant !== 1'h1 && seen_v < lim) begin
      step(1);
      seen_v++;
    end
  endtask : wait_grant

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (factory_default_restore === 1'h1) fdr_n++;
    if (cyc == LIM) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    step(8);
    rst = 1'h0;
    note(7, 64'(dflt()));
    for (int i = 0; i < 8; i++) begin
      aux_func = 4'($random(seed));
      oia = 4'($random(seed));
      wr(alarm_cond_pkg::SEL_OPEN_ALARM, {10'h0, oia});
      step(1);
      note(0, 64'(aux_func ^ oia));
      note(1, 64'(aux_func));
    end
    wr(alarm_cond_pkg::SEL_HB_HOLD, 14'h1);
    for (int k = 0; k < 7; k++) begin
      pulse(heater_break_alarm);
      step(3);
      note(2, 64'h1);
      if (k < 2) i_alarm_partner.press(k, 3);
      else if (k == 2) hb_threshold_zero = 1'h1;
      else level = alarm_cond_pkg::level_t'(k - 2);
      step(8);
      note(2, 64'h0);
      hb_threshold_zero = 1'h0;
      level = alarm_cond_pkg::LVL_OPERATION;
      step(3);
      note(2, 64'h0);
    end
    wr(alarm_cond_pkg::SEL_HB_ENABLE, 14'h0);
    pulse(heater_break_alarm);
    step(3);
    note(2, 64'h0);
    wr(alarm_cond_pkg::SEL_HB_ENABLE, 14'h1);
    wr(alarm_cond_pkg::SEL_HB_HOLD, 14'h0);
    pulse(heater_break_alarm);
    note(2, 64'h1);
    step(3);
    note(2, 64'h0);
    foreach (pw_tab[j]) begin
      wr(alarm_cond_pkg::SEL_FINISH, pw_tab[j]);
      pulse(program_end);
      hi_n = run_finish_out;
      repeat (pw_tab[j] * STEP + 20) begin
        step(1);
        hi_n += run_finish_out;
      end
      seen_v = (pw_tab[j] == 0) ? (hi_n == 0) : (hi_n - pw_tab[j] * STEP) inside {0, 1};
      note(8, 64'h1);
    end
    wr(alarm_cond_pkg::SEL_FINISH, 14'h65);
    seen_v = 64'(cfg.run_finish_pulse_width);
    note(8, 64'h64);
    wr(alarm_cond_pkg::SEL_FINISH_CONT, 14'h1);
    pulse(program_end);
    step(40);
    note(4, 64'h1);
    pulse(run_cmd);
    step(3);
    note(4, 64'h1);
    in_reset_status = 1'h1;
    pulse(run_cmd);
    in_reset_status = 1'h0;
    step(2);
    note(4, 64'h0);
    alarm_raw = 4'hf;
    for (int t = 0; t < 16; t++) begin
      alarm_type = {4{4'(t)}};
      rearm_event = 9'h1 << (t % 9);
      step(1);
      rearm_event = 9'h0;
      step(3);
      note(3, (t inside {5, 6, 7, 10, 11}) ? 64'h0 : 64'hf);
      alarm_raw = 4'h0;
      step(2);
      alarm_raw = 4'hf;
      step(3);
      note(3, 64'hf);
    end
    alarm_type = {4{4'h5}};
    wr(alarm_cond_pkg::SEL_REARM, 14'h1);
    rearm_event = 9'h1ff;
    step(1);
    rearm_event = 9'h0;
    step(3);
    note(3, 64'hf);
    for (int k = 1; k < 5; k++) begin
      level = alarm_cond_pkg::level_t'(k);
      step(3);
      note(3, 64'h0);
    end
    alarm_raw = 4'h0;
    wr(alarm_cond_pkg::SEL_ROOT, 14'h1);
    wr(alarm_cond_pkg::SEL_UNIT, 14'h1);
    seen_v = {cfg.root_extract_enable, cfg.standby_unit_days};
    note(8, 64'h3);
    wr(alarm_cond_pkg::SEL_VALVE_OPEN, 14'h2710);
    wr(alarm_cond_pkg::SEL_POT_RANGE, 14'h6);
    seen_v = {cfg.valve_open_pos, cfg.pot_range_code};
    note(8, {14'h270f, 3'h0});
    cal_open_pos = 14'h4d2;
    cal_pot_code = 3'h5;
    pulse(cal_done);
    step(1);
    seen_v = {cfg.valve_open_pos, cfg.pot_range_code};
    note(8, {14'h4d2, 3'h5});
    fdr_n = 0;
    wr(alarm_cond_pkg::SEL_RESTORE, 14'h1);
    note(7, 64'(dflt()));
    step(2);
    seen_v = fdr_n;
    note(8, 64'h1);
    protect_zero = 1'h1;
    wr(alarm_cond_pkg::SEL_PASSWORD, 14'h3f57);
    wait_grant(40);
    note(8, 64'd40);
    level = alarm_cond_pkg::LVL_INITIAL;
    wr(alarm_cond_pkg::SEL_PASSWORD, 14'h0169);
    wait_grant(40);
    note(8, 64'd40);
    protect_zero = 1'h0;
    wr(alarm_cond_pkg::SEL_PASSWORD, 14'h3f57);
    wait_grant(40);
    note(8, 64'd40);
    protect_zero = 1'h1;
    wr(alarm_cond_pkg::SEL_PASSWORD, 14'h3f57);
    fork
      i_alarm_partner.press(2, 3);
    join_none
    wait_grant(15);
    seen_v = (seen_v < 15);
    note(8, 64'h1);
    step(2);
    wr(alarm_cond_pkg::SEL_PASSWORD, 14'h3f57);
    wait_grant(40);
    seen_v = (seen_v >= 15 && seen_v <= 25);
    note(8, 64'h1);
    step(2);
    end_of_test();
  end
endmodule : tb_top
